// [rcs_pkg.sv]
// package for the rotate/subtract execution datapath: widths, bit positions,
// reset values and the operation codes handed over by the instruction decoder.
// assumes one 20 MHz instruction clock and an active-low asynchronous reset.
`default_nettype none

package rcs_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned MSB      = 7;   // sign bit / rotate fill position
  localparam int unsigned LSB      = 0;   // bit shifted out into carry
  localparam int unsigned NIB_W    = 4;   // low nibble for half borrow
  localparam logic [7:0]  WORK_RST = 8'h00;
  localparam logic        FLAG_RST = 1'b0;

  // one-cycle operation request from the decoder
  typedef enum logic [2:0] {
    RCS_OP_NONE     = 3'h0,
    RCS_OP_ROT_WORK = 3'h1,   // rot_right_flag_to_work
    RCS_OP_SBC_MEM  = 3'h2,   // subtract_with_borrow, memory operand
    RCS_OP_SBC_IMM  = 3'h3,   // subtract_with_borrow, immediate operand
    RCS_OP_SBC_TO_M = 3'h4    // subtract_with_borrow_to_memory
  } rcs_op_t;

endpackage

`default_nettype wire

// [rcs_sub_if.sv]
// interface between the datapath top and its subtract unit.
// assumes both ends sit in the same clock domain; purely combinational wires.
`default_nettype none

interface rcs_sub_if;
  import rcs_pkg::*;

  logic [DATA_W-1:0] minuend;
  logic [DATA_W-1:0] subtrahend;
  logic              carry_in;       // carry flag, borrow is its complement
  logic [DATA_W-1:0] difference;
  logic              carry_out;      // inverted borrow
  logic              half_borrow;
  logic              signed_wrap;
  logic              signed_borrow;

  modport unit (input minuend, input subtrahend, input carry_in,
                output difference, output carry_out, output half_borrow,
                output signed_wrap, output signed_borrow);
  modport user (output minuend, output subtrahend, output carry_in,
                input difference, input carry_out, input half_borrow,
                input signed_wrap, input signed_borrow);
endinterface

`default_nettype wire

// [rcs_sub_unit.sv]
// combinational subtract-with-borrow unit: difference and arithmetic flags.
// assumes the caller registers every result it keeps.
`default_nettype none

module rcs_sub_unit
  import rcs_pkg::*;
(
  rcs_sub_if.unit sif
);

  logic [DATA_W:0]  wide_diff;
  logic [NIB_W:0]   nib_diff;
  logic [DATA_W:0]  borrow_wide;
  logic [NIB_W:0]   borrow_nib;

  // nine-bit subtract so the borrow falls out of the top bit
  always_comb begin
    borrow_wide        = {{DATA_W{1'b0}}, ~sif.carry_in};
    borrow_nib         = {{NIB_W{1'b0}}, ~sif.carry_in};
    wide_diff          = {1'b0, sif.minuend} - {1'b0, sif.subtrahend} - borrow_wide;
    nib_diff           = {1'b0, sif.minuend[NIB_W-1:0]} - {1'b0, sif.subtrahend[NIB_W-1:0]} - borrow_nib;
    sif.difference     = wide_diff[DATA_W-1:0];
    sif.carry_out      = ~wide_diff[DATA_W];       // negative clears carry
    sif.half_borrow    = nib_diff[NIB_W];          // borrow out of low nibble
    // operands of unlike sign and a result whose sign left the minuend's
    sif.signed_wrap    = (sif.minuend[MSB] ^ sif.subtrahend[MSB]) & (wide_diff[MSB] ^ sif.minuend[MSB]);
    // true signed less-than: sign corrected by overflow
    sif.signed_borrow  = wide_diff[MSB] ^ sif.signed_wrap;
  end

endmodule

`default_nettype wire

// [rcs_alu.sv]
// execution datapath for rotate-right-through-carry into the working register
// and the subtract-with-borrow family, with the status flags they touch.
// assumes the decoder issues at most one op per clock as a one-cycle pulse and
// presents the memory operand in the same cycle; memory writes are one cycle later.
`default_nettype none

module rcs_alu
  import rcs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              op_valid,
  input  wire rcs_op_t           op_code,
  input  wire logic [DATA_W-1:0] mem_operand,
  input  wire logic [DATA_W-1:0] imm_operand,
  output logic [DATA_W-1:0]      working_register,
  output logic                   carry_flag,
  output logic                   zero_flag,
  output logic                   signed_wrap_flag,
  output logic                   half_borrow_flag,
  output logic                   signed_borrow_flag,
  output logic                   borrow_and_nil_flag,
  output logic                   mem_wr_en,
  output logic [DATA_W-1:0]      mem_wr_data
);

  rcs_sub_if sub_bus ();

  logic [DATA_W-1:0] work_reg;
  logic [DATA_W-1:0] work_next;
  logic              carry_reg;
  logic              carry_next;
  logic              zero_reg;
  logic              zero_next;
  logic              wrap_reg;
  logic              wrap_next;
  logic              half_reg;
  logic              half_next;
  logic              sgn_reg;
  logic              sgn_next;
  logic              cz_reg;
  logic              cz_next;
  logic              wr_en_reg;
  logic              wr_en_next;
  logic [DATA_W-1:0] wr_data_reg;
  logic [DATA_W-1:0] wr_data_next;

  logic              is_rot;
  logic              is_sub;
  logic [DATA_W-1:0] rot_value;
  logic              diff_zero;

  rcs_sub_unit u_sub (
    .sif (sub_bus)
  );

  // decode; an unknown code is treated as no operation
  assign is_rot = op_valid && (op_code == RCS_OP_ROT_WORK);
  assign is_sub = op_valid && ((op_code == RCS_OP_SBC_MEM) || (op_code == RCS_OP_SBC_IMM) ||
                               (op_code == RCS_OP_SBC_TO_M));

  // subtract operands: the immediate variant swaps in the instruction field
  assign sub_bus.minuend    = work_reg;
  assign sub_bus.subtrahend = (op_code == RCS_OP_SBC_IMM) ? imm_operand : mem_operand;
  assign sub_bus.carry_in   = carry_reg;
  assign diff_zero          = (sub_bus.difference == WORK_RST);

  // rotate right through carry: old carry sampled before it is replaced
  assign rot_value = {carry_reg, mem_operand[MSB:LSB+1]};

  // next-state for the working register, flags and the memory write port
  always_comb begin
    work_next    = work_reg;
    carry_next   = carry_reg;
    zero_next    = zero_reg;
    wrap_next    = wrap_reg;
    half_next    = half_reg;
    sgn_next     = sgn_reg;
    cz_next      = cz_reg;
    wr_en_next   = 1'b0;
    wr_data_next = wr_data_reg;
    if (is_rot) begin
      work_next  = rot_value;
      carry_next = mem_operand[LSB];
    end else if (is_sub) begin
      carry_next = sub_bus.carry_out;
      zero_next  = diff_zero;
      wrap_next  = sub_bus.signed_wrap;
      half_next  = sub_bus.half_borrow;
      sgn_next   = sub_bus.signed_borrow;
      // chained zero: set only when this difference is zero and the previous zero flag is set
      cz_next    = diff_zero & zero_reg;
      if (op_code == RCS_OP_SBC_TO_M) begin
        wr_en_next   = 1'b1;
        wr_data_next = sub_bus.difference;
      end else begin
        work_next    = sub_bus.difference;
      end
    end
  end

  // state registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      work_reg    <= WORK_RST;
      carry_reg   <= FLAG_RST;
      zero_reg    <= FLAG_RST;
      wrap_reg    <= FLAG_RST;
      half_reg    <= FLAG_RST;
      sgn_reg     <= FLAG_RST;
      cz_reg      <= FLAG_RST;
      wr_en_reg   <= 1'b0;
      wr_data_reg <= WORK_RST;
    end else begin
      work_reg    <= work_next;
      carry_reg   <= carry_next;
      zero_reg    <= zero_next;
      wrap_reg    <= wrap_next;
      half_reg    <= half_next;
      sgn_reg     <= sgn_next;
      cz_reg      <= cz_next;
      wr_en_reg   <= wr_en_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // all outputs straight from flops so the core sees no decode glitches
  assign working_register    = work_reg;
  assign carry_flag          = carry_reg;
  assign zero_flag           = zero_reg;
  assign signed_wrap_flag    = wrap_reg;
  assign half_borrow_flag    = half_reg;
  assign signed_borrow_flag  = sgn_reg;
  assign borrow_and_nil_flag = cz_reg;
  assign mem_wr_en           = wr_en_reg;
  assign mem_wr_data         = wr_data_reg;

  // helpers read only by the checks below, built independently of the datapath
  logic [DATA_W-1:0] chk_mem_hi;
  logic              chk_mem_lsb;
  logic [DATA_W-1:0] chk_operand;
  logic              chk_ge;
  logic              chk_nib_lt;
  logic [DATA_W-1:0] chk_diff;
  logic              chk_wrap;
  logic [DATA_W+1:0] chk_sdiff;
  assign chk_mem_hi  = {1'b0, mem_operand[MSB:LSB+1]};
  assign chk_mem_lsb = mem_operand[LSB];
  assign chk_operand = (op_code == RCS_OP_SBC_IMM) ? imm_operand : mem_operand;
  assign chk_ge      = ({1'b0, work_reg} >= ({1'b0, chk_operand} + {{DATA_W{1'b0}}, ~carry_reg}));
  // nibble borrow, plain difference, and a sign-extended difference whose top bit is the true sign;
  // the extra two bits keep the signed result from wrapping, so no overflow correction is needed
  assign chk_nib_lt  = ({1'b0, work_reg[NIB_W-1:0]} < ({1'b0, chk_operand[NIB_W-1:0]} + {{NIB_W{1'b0}}, ~carry_reg}));
  assign chk_diff    = work_reg - chk_operand - {{MSB{1'b0}}, ~carry_reg};
  assign chk_wrap    = (work_reg[MSB] != chk_operand[MSB]) && (chk_diff[MSB] != work_reg[MSB]);
  assign chk_sdiff   = {{2{work_reg[MSB]}}, work_reg} - {{2{chk_operand[MSB]}}, chk_operand}
                       - {{(DATA_W+1){1'b0}}, ~carry_reg};

  // every check looks one cycle after the op edge; reset masks them all
  a_rot_high_bit: assert property (@(posedge clk) disable iff (!rst_n)
    is_rot |=> working_register[MSB] == $past(carry_flag)) else $error("rotate fill bit wrong");
  a_rot_low_bits: assert property (@(posedge clk) disable iff (!rst_n)
    is_rot |=> {1'b0, working_register[MSB-1:0]} == $past(chk_mem_hi)) else $error("rotate low bits wrong");
  a_rot_carry_in: assert property (@(posedge clk) disable iff (!rst_n)
    is_rot |=> carry_flag == $past(chk_mem_lsb)) else $error("rotate carry wrong");
  a_rot_keeps_rest: assert property (@(posedge clk) disable iff (!rst_n)
    is_rot |=> !mem_wr_en && $stable(zero_flag) && $stable(signed_wrap_flag) && $stable(half_borrow_flag)
               && $stable(signed_borrow_flag) && $stable(borrow_and_nil_flag))
    else $error("rotate touched memory or flags");
  a_sbc_mem_work: assert property (@(posedge clk) disable iff (!rst_n)
    (op_valid && op_code == RCS_OP_SBC_MEM) |=>
      working_register == $past(working_register) - $past(mem_operand) - {{MSB{1'b0}}, ~$past(carry_flag)})
    else $error("memory subtract result wrong");
  a_sbc_imm_work: assert property (@(posedge clk) disable iff (!rst_n)
    (op_valid && op_code == RCS_OP_SBC_IMM) |=>
      working_register == $past(working_register) - $past(imm_operand) - {{MSB{1'b0}}, ~$past(carry_flag)})
    else $error("immediate subtract result wrong");
  a_sbc_to_mem: assert property (@(posedge clk) disable iff (!rst_n)
    (op_valid && op_code == RCS_OP_SBC_TO_M) |=> mem_wr_en && $stable(working_register) &&
      mem_wr_data == $past(working_register) - $past(mem_operand) - {{MSB{1'b0}}, ~$past(carry_flag)})
    else $error("subtract to memory wrong");
  a_sbc_carry: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub |=> carry_flag == $past(chk_ge)) else $error("subtract carry wrong");
  a_sbc_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (op_valid && op_code != RCS_OP_SBC_TO_M) && is_sub |=> zero_flag == (working_register == WORK_RST))
    else $error("subtract zero flag wrong");
  a_idle_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !op_valid |=> $stable(working_register) && $stable(carry_flag) && $stable(zero_flag) && !mem_wr_en)
    else $error("state changed without an op");

  // arithmetic flags of every subtract variant, and the refused codes
  a_sbc_half_flag: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub |=> half_borrow_flag == $past(chk_nib_lt)) else $error("subtract half borrow wrong");
  a_sbc_wrap_flag: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub |=> signed_wrap_flag == $past(chk_wrap)) else $error("subtract signed wrap wrong");
  a_sbc_sign_flag: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub |=> signed_borrow_flag == $past(chk_sdiff[DATA_W+1])) else $error("subtract signed borrow wrong");
  a_sbc_chain_zero: assert property (@(posedge clk) disable iff (!rst_n)
    is_sub |=> borrow_and_nil_flag == (($past(chk_diff) == WORK_RST) && $past(zero_flag)))
    else $error("subtract chained zero wrong");
  a_to_mem_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (op_valid && op_code == RCS_OP_SBC_TO_M) |=> zero_flag == (mem_wr_data == WORK_RST)) else $error("memory zero wrong");
  a_wr_from_op: assert property (@(posedge clk) disable iff (!rst_n)
    mem_wr_en |-> $past(op_valid && op_code == RCS_OP_SBC_TO_M)) else $error("memory write without its op");
  a_bad_code_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (op_valid && !is_rot && !is_sub) |=> $stable(working_register) && $stable(carry_flag) && $stable(zero_flag)
      && $stable(borrow_and_nil_flag) && !mem_wr_en) else $error("refused code changed state");

endmodule

`default_nettype wire

// [rcs_alu_bench.sv]
// self-checking bench for the rotate/subtract datapath: an integer model is
// compared with the design after every clock. assumes rcs_pkg and rcs_sub_if,
// rcs_sub_unit and rcs_alu are compiled first; the bench drives all ports itself.
`default_nettype none

module rcs_alu_bench
  import rcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk;
  logic              rst_n;
  logic              op_valid;
  rcs_op_t           op_code;
  logic [DATA_W-1:0] mem_operand;
  logic [DATA_W-1:0] imm_operand;
  wire logic [7:0]   working_register;
  wire logic         carry_flag;
  wire logic         zero_flag;
  wire logic         signed_wrap_flag;
  wire logic         half_borrow_flag;
  wire logic         signed_borrow_flag;
  wire logic         borrow_and_nil_flag;
  wire logic         mem_wr_en;
  wire logic [7:0]   mem_wr_data;
  int                errors;
  int                n_compared;
  int                seed;
  // model state: work, carry, zero, wrap, half, signed, borrow-nil, mem data, mem strobe
  int                w, c, z, ov, ac, sc, cz, wdat, wen;

  rcs_alu dut (
    .clk                 (clk),
    .rst_n               (rst_n),
    .op_valid            (op_valid),
    .op_code             (op_code),
    .mem_operand         (mem_operand),
    .imm_operand         (imm_operand),
    .working_register    (working_register),
    .carry_flag          (carry_flag),
    .zero_flag           (zero_flag),
    .signed_wrap_flag    (signed_wrap_flag),
    .half_borrow_flag    (half_borrow_flag),
    .signed_borrow_flag  (signed_borrow_flag),
    .borrow_and_nil_flag (borrow_and_nil_flag),
    .mem_wr_en           (mem_wr_en),
    .mem_wr_data         (mem_wr_data)
  );

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // reference behaviour; codes outside 1..4 or no valid leave everything alone except the mem strobe, which drops
  task automatic model(input int v, input int code, input int m, input int i);
    int opd, d, r;
    wen = 0;
    if (v == 1 && code == 1) begin
      w = (c << 7) | (m >> 1);
      c = m & 1;
    end else if (v == 1 && code >= 2 && code <= 4) begin
      opd = (code == 3) ? i : m;
      d = w - opd - (1 - c);
      r = d & 255;
      ac = ((w & 15) - (opd & 15) - (1 - c)) < 0;
      ov = ((w ^ opd) & (w ^ r) & 128) != 0;
      sc = ((r >> 7) & 1) ^ ov;
      cz = (r == 0) && (z == 1);  // chained zero uses the old zero flag
      z = (r == 0);
      c = (d >= 0);
      if (code == 4) begin
        wdat = r;
        wen = 1;
      end else begin
        w = r;
      end
    end
  endtask

  task automatic compare_all;
    check(working_register, 8'(w));
    check(8'(carry_flag), 8'(c));
    check(8'(zero_flag), 8'(z));
    check(8'(signed_wrap_flag), 8'(ov));
    check(8'(half_borrow_flag), 8'(ac));
    check(8'(signed_borrow_flag), 8'(sc));
    check(8'(borrow_and_nil_flag), 8'(cz));
    check(8'(mem_wr_en), 8'(wen));
    check(mem_wr_data, 8'(wdat));
  endtask

  // drive at the falling edge, let the rising edge take it, compare at the next fall
  task automatic op(input logic v, input rcs_op_t code, input logic [7:0] m, input logic [7:0] i);
    op_valid = v;
    op_code = code;
    mem_operand = m;
    imm_operand = i;
    @(posedge clk);
    model(int'(v), int'(code), int'(m), int'(i));
    @(negedge clk);
    compare_all();
  endtask

  // watchdog: the run needs well under 1000 cycles
  initial begin
    #100000;
    errors++;
    give_verdict();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    seed = 56407;
    {w, c, z, ov, ac, sc, cz, wdat, wen} = '0;
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_code = RCS_OP_NONE;
    mem_operand = 8'h00;
    imm_operand = 8'h00;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    compare_all();
    // borrow from zero, rotate both carry values, zero chain, no-op and idle
    op(1'b1, RCS_OP_SBC_MEM, 8'h00, 8'h5a);
    op(1'b1, RCS_OP_ROT_WORK, 8'h01, 8'h00);
    op(1'b1, RCS_OP_ROT_WORK, 8'h80, 8'h00);
    op(1'b1, RCS_OP_ROT_WORK, 8'h01, 8'h00);
    op(1'b1, RCS_OP_SBC_IMM, 8'hff, 8'h00);
    op(1'b1, RCS_OP_SBC_TO_M, 8'h00, 8'h00);
    op(1'b1, RCS_OP_SBC_TO_M, 8'h7f, 8'h00);
    op(1'b1, RCS_OP_NONE, 8'h33, 8'h33);
    op(1'b0, RCS_OP_SBC_MEM, 8'h33, 8'h33);
    // random back-to-back mix, unknown codes included
    for (int k = 0; k < 400; k++) begin
      op(1'(($random(seed) & 3) != 0), rcs_op_t'(3'($random(seed))), 8'($random(seed)), 8'($random(seed)));
    end
    give_verdict();
  end
endmodule

`default_nettype wire
